/* File: src/debug_bridge_pkg.sv */
package debug_bridge_pkg;

    // ----------------------------------------------------------------
    // widths and timing
    // ----------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 16;
    localparam int CLK_PERIOD_NS = 40;
    localparam int STEP_MIN_NS = 500;
    localparam int STEP_MAX_NS = 1000;
    // strictly longer than the least time, strictly shorter than the longest
    localparam int STEP_CYCLES = STEP_MIN_NS / CLK_PERIOD_NS + 1;
    localparam int STEP_MAX_CYCLES = (STEP_MAX_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_CNT_W = 8;

    // ----------------------------------------------------------------
    // select codes {select_high, select_low}
    // ----------------------------------------------------------------
    localparam logic [1:0] SEL_ADDR_HIGH = 2'h0;
    localparam logic [1:0] SEL_ADDR_LOW = 2'h1;
    localparam logic [1:0] SEL_DATA_BUS = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;

    // ----------------------------------------------------------------
    // reset values: slave runs, nothing injected or protected
    // ----------------------------------------------------------------
    localparam logic [7:0] KEY_CODE_RESET = 8'h00;
    localparam logic [7:0] JAM_DATA_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'hFF;
    localparam logic [15:0] ADDR_HIGH_LSB = 16'h0008;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        TARGET_KEY_CODE,
        TARGET_CONTROL,
        TARGET_JAM_DATA
    } target_t;

    // bit 7 down to bit 0 of the slave control register
    typedef struct packed {
        logic key_ready;
        logic phantom;
        logic drivers_enable;
        logic write_enable;
        logic run_reset;
        logic inject_off;
        logic step;
        logic run;
    } control_t;

    // bit 7 down to bit 0 as presented on host_in_data
    typedef struct packed {
        logic pwait;
        logic pdbin;
        logic spare;
        logic mem_write_status;
        logic sstack;
        logic sout;
        logic sinp;
        logic sm1;
    } status_t;

    typedef struct packed {
        logic select_high;
        logic select_low;
    } select_t;

endpackage

/* File: src/step_release.sv */
`timescale 1ns/1ps

module step_release #(
    parameter int CYCLES = debug_bridge_pkg::STEP_CYCLES
) (
    input wire logic CLK, // system clock
    input wire logic RST, // synchronous reset, active high
    input wire logic start, // one-cycle request to release the ready line
    output logic active // high while the ready line is released
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (CYCLES < 1 || CYCLES > debug_bridge_pkg::STEP_MAX_CYCLES ||
        CYCLES >= (1 << debug_bridge_pkg::STEP_CNT_W)) begin : g_bad_cycles
        $error("step_release: CYCLES out of range");
    end

    typedef struct packed {
        logic [debug_bridge_pkg::STEP_CNT_W-1:0] count;
    } step_state_t;

    step_state_t state_reg;
    step_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (start) begin
            state_next.count = debug_bridge_pkg::STEP_CNT_W'(CYCLES);
        end else if (state_reg.count != '0) begin
            state_next.count = state_reg.count - 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign active = (state_reg.count != '0);

endmodule // step_release

/* File: src/debug_bridge.sv */
// What this block does
// - rising edge of the output strobe loads the selected 8-bit register
// - selects pick input group (addr high, addr low, data bus, status) and target (key code, key code, control, jam data)
// - status group order: SM1, SINP, SOUT, SSTACK, mem write, spare, PDBIN, PWAIT
// - control bit 0 low pulls the slave ready line low
// - bit 1 rising while halted releases ready for 500 ns to 1 us
// - bit 2 low asserts data inject and drives jam data onto bus
// - bit 3 drives the active-low slave reset line
// - bit 4 low asserts front ready and forces memory write low
// - bit 5 drives the active-low data-out disable line
// - bit 6 drives the active-low phantom line
// - bit 7 drives key ready; its rising edge sets slave key flag
// - key code register shown continuously on the keyboard header
// - slave control only per machine cycle, never within clock states
`timescale 1ns/1ps

module debug_bridge #(
    parameter int STEP_CYCLES = debug_bridge_pkg::STEP_CYCLES
) (
    input wire logic CLK, // 25 MHz system clock
    input wire logic RST, // synchronous reset, active high
    input wire logic [7:0] HOST_OUT_DATA, // data from master parallel port
    input wire logic HOST_OUT_STROBE_N, // master output strobe, active low
    input wire logic SELECT_LOW, // master select line, low bit
    input wire logic SELECT_HIGH, // master select line, high bit
    output logic [7:0] HOST_IN_DATA, // data to master parallel port
    input wire logic [15:0] ADDR, // slave address bus
    input wire logic [7:0] DATA_BUS_IN, // slave bidirectional data bus, sensed
    output logic [7:0] DATA_BUS_OUT, // jam data driven onto the data bus
    output logic DATA_BUS_OE_N, // low while the jam data drives the bus
    input wire debug_bridge_pkg::status_t STATUS, // slave status lines
    output logic XRDY_OUT, // ready line level when driven (always low)
    output logic XRDY_OE_N, // low while the ready line is pulled low
    output logic DATA_INJECT_N, // data inject, active low
    output logic PRESET_N, // slave reset, active low
    output logic FRONT_READY_N, // disables slave write driver, active low
    output logic MWRITE_OUT, // memory write level when driven (always low)
    output logic MWRITE_OE_N, // low while memory write is forced low
    output logic DO_DSBL_N, // slave data-out disable, active low
    output logic PHANTOM_N, // phantom, active low
    output logic KEY_READY_N, // keyboard data ready, active low
    output logic [7:0] KEY_CODE // keyboard header data
);

    // ----------------------------------------------------------------
    // elaboration check
    // ----------------------------------------------------------------
    if (STEP_CYCLES < 1 || STEP_CYCLES > debug_bridge_pkg::STEP_MAX_CYCLES) begin : g_bad_step
        $error("debug_bridge: STEP_CYCLES outside the allowed release window");
    end

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic debug_bridge_pkg::target_t target_of(input debug_bridge_pkg::select_t sel);
        case ({sel.select_high, sel.select_low})
            debug_bridge_pkg::SEL_ADDR_HIGH: target_of = debug_bridge_pkg::TARGET_KEY_CODE;
            debug_bridge_pkg::SEL_ADDR_LOW: target_of = debug_bridge_pkg::TARGET_KEY_CODE;
            debug_bridge_pkg::SEL_DATA_BUS: target_of = debug_bridge_pkg::TARGET_CONTROL;
            default: target_of = debug_bridge_pkg::TARGET_JAM_DATA;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic strobe_n;
        logic [7:0] key_code;
        logic [7:0] jam_data;
        debug_bridge_pkg::control_t control;
        logic step_start;
    } bridge_state_t;

    bridge_state_t state_reg;
    bridge_state_t state_next;
    debug_bridge_pkg::select_t sel;
    logic strobe_rise;
    logic step_active;

    assign sel = '{select_high: SELECT_HIGH, select_low: SELECT_LOW};
    // the strobe is sampled, so a load lands on the same edge that first sees the rising strobe level
    assign strobe_rise = state_reg.strobe_n == 1'b0 && HOST_OUT_STROBE_N == 1'b1;

    always_comb begin
        state_next = state_reg;
        state_next.strobe_n = HOST_OUT_STROBE_N;
        state_next.step_start = 1'b0;
        if (strobe_rise) begin
            case (target_of(sel))
                debug_bridge_pkg::TARGET_KEY_CODE: begin
                    state_next.key_code = HOST_OUT_DATA;
                end
                debug_bridge_pkg::TARGET_CONTROL: begin
                    state_next.control = debug_bridge_pkg::control_t'(HOST_OUT_DATA);
                    // a step only means something while the slave is held; checked on the new value
                    state_next.step_start = !state_reg.control.step && HOST_OUT_DATA[1]
                        && !HOST_OUT_DATA[0];
                end
                debug_bridge_pkg::TARGET_JAM_DATA: begin
                    state_next.jam_data = HOST_OUT_DATA;
                end
                default: begin
                    state_next.key_code = state_reg.key_code;
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_reg.strobe_n <= 1'b1;
            state_reg.key_code <= debug_bridge_pkg::KEY_CODE_RESET;
            state_reg.jam_data <= debug_bridge_pkg::JAM_DATA_RESET;
            state_reg.control <= debug_bridge_pkg::control_t'(debug_bridge_pkg::CONTROL_RESET);
            state_reg.step_start <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------------------------------
    // single-step release of the ready line
    // ----------------------------------------------------------------
    step_release #(
        .CYCLES(STEP_CYCLES)
    ) u_step (
        .CLK(CLK),
        .RST(RST),
        .start(state_reg.step_start),
        .active(step_active)
    );

    // ----------------------------------------------------------------
    // input multiplexer toward the master
    // ----------------------------------------------------------------
    always_comb begin
        case ({sel.select_high, sel.select_low})
            debug_bridge_pkg::SEL_ADDR_HIGH: HOST_IN_DATA = ADDR[15:8];
            debug_bridge_pkg::SEL_ADDR_LOW: HOST_IN_DATA = ADDR[7:0];
            debug_bridge_pkg::SEL_DATA_BUS: HOST_IN_DATA = DATA_BUS_IN;
            default: HOST_IN_DATA = STATUS;
        endcase
    end

    // ----------------------------------------------------------------
    // slave bus controls
    // ----------------------------------------------------------------
    // holding the ready line only freezes the slave between clock states, whole cycles at a time
    assign XRDY_OUT = 1'b0;
    assign XRDY_OE_N = state_reg.control.run | step_active;
    assign DATA_INJECT_N = state_reg.control.inject_off;
    assign DATA_BUS_OUT = state_reg.jam_data;
    assign DATA_BUS_OE_N = state_reg.control.inject_off;
    assign PRESET_N = state_reg.control.run_reset;
    assign FRONT_READY_N = state_reg.control.write_enable;
    assign MWRITE_OUT = 1'b0;
    assign MWRITE_OE_N = state_reg.control.write_enable;
    assign DO_DSBL_N = state_reg.control.drivers_enable;
    assign PHANTOM_N = state_reg.control.phantom;
    // the slave latches its key flag on this line's rising edge, so no pulse shaping here
    assign KEY_READY_N = state_reg.control.key_ready;
    assign KEY_CODE = state_reg.key_code;

endmodule // debug_bridge

/* File: tb/debug_bridge_properties.sv */
`timescale 1ns/1ps

module debug_bridge_properties #(
    parameter int STEP_CYCLES = debug_bridge_pkg::STEP_CYCLES
) (
    input wire logic CLK, input wire logic RST, input wire logic [7:0] HOST_OUT_DATA,
    input wire logic HOST_OUT_STROBE_N, input wire logic SELECT_LOW, input wire logic SELECT_HIGH,
    input wire logic [7:0] HOST_IN_DATA, input wire logic [15:0] ADDR, input wire logic [7:0] DATA_BUS_IN,
    input wire logic [7:0] DATA_BUS_OUT, input wire logic DATA_BUS_OE_N, input wire debug_bridge_pkg::status_t STATUS,
    input wire logic XRDY_OUT, input wire logic XRDY_OE_N, input wire logic DATA_INJECT_N, input wire logic PRESET_N,
    input wire logic FRONT_READY_N, input wire logic MWRITE_OUT, input wire logic MWRITE_OE_N,
    input wire logic DO_DSBL_N, input wire logic PHANTOM_N, input wire logic KEY_READY_N, input wire logic [7:0] KEY_CODE
);
    localparam int HOLD_LAST = STEP_CYCLES - 1;
    logic strobe_reg, run_reg, step_reg, load;
    logic [1:0] sel;
    assign sel = {SELECT_HIGH, SELECT_LOW};
    assign load = HOST_OUT_STROBE_N && !strobe_reg;
    // shadow of control bits 1..0, reset to the designer's all-ones value
    always_ff @(posedge CLK) begin
        strobe_reg <= RST ? 1'b1 : HOST_OUT_STROBE_N;
        if (RST) {step_reg, run_reg} <= 2'h3;
        else if (load && sel == 2'h2) {step_reg, run_reg} <= HOST_OUT_DATA[1:0];
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    a_key_load: assert property (load && !sel[1] |=> KEY_CODE == $past(HOST_OUT_DATA))
        else $error("key code not loaded");
    a_jam_load: assert property (load && sel == 2'h3 |=> DATA_BUS_OUT == $past(HOST_OUT_DATA))
        else $error("jam data not loaded");
    a_control_lines: assert property (load && sel == 2'h2 |=>
        {KEY_READY_N, PHANTOM_N, DO_DSBL_N, FRONT_READY_N, PRESET_N, DATA_INJECT_N, DATA_BUS_OE_N}
        == {$past(HOST_OUT_DATA[7:2]), $past(HOST_OUT_DATA[2])}) else $error("control lines wrong");
    a_write_protect: assert property (MWRITE_OE_N == FRONT_READY_N && !MWRITE_OUT && !XRDY_OUT)
        else $error("write protect wrong");
    a_mux_status: assert property (sel == 2'h3 |-> HOST_IN_DATA == STATUS)
        else $error("status group wrong");
    a_mux_other: assert property (sel != 2'h3 |-> HOST_IN_DATA ==
        (sel == 2'h0 ? ADDR[15:8] : sel == 2'h1 ? ADDR[7:0] : DATA_BUS_IN)) else $error("input group wrong");
    a_run_release: assert property (run_reg |-> XRDY_OE_N)
        else $error("ready held while running");
    a_step_start: assert property (load && sel == 2'h2 && HOST_OUT_DATA[1:0] == 2'h2 && !step_reg
        |-> ##[1:3] XRDY_OE_N) else $error("step did not release ready");
    a_step_hold: assert property ($rose(XRDY_OE_N) && !run_reg |-> ##HOLD_LAST XRDY_OE_N ##1 !XRDY_OE_N)
        else $error("step width wrong");
endmodule // debug_bridge_properties

bind debug_bridge debug_bridge_properties #(.STEP_CYCLES(STEP_CYCLES)) debug_bridge_properties_inst (
    .CLK(CLK), .RST(RST), .HOST_OUT_DATA(HOST_OUT_DATA), .HOST_OUT_STROBE_N(HOST_OUT_STROBE_N),
    .SELECT_LOW(SELECT_LOW), .SELECT_HIGH(SELECT_HIGH), .HOST_IN_DATA(HOST_IN_DATA), .ADDR(ADDR),
    .DATA_BUS_IN(DATA_BUS_IN), .DATA_BUS_OUT(DATA_BUS_OUT), .DATA_BUS_OE_N(DATA_BUS_OE_N), .STATUS(STATUS),
    .XRDY_OUT(XRDY_OUT), .XRDY_OE_N(XRDY_OE_N), .DATA_INJECT_N(DATA_INJECT_N), .PRESET_N(PRESET_N),
    .FRONT_READY_N(FRONT_READY_N),
    .MWRITE_OUT(MWRITE_OUT), .MWRITE_OE_N(MWRITE_OE_N), .DO_DSBL_N(DO_DSBL_N), .PHANTOM_N(PHANTOM_N),
    .KEY_READY_N(KEY_READY_N), .KEY_CODE(KEY_CODE));

/* File: tb/slave_bus_model.sv */
`timescale 1ns/1ps

module slave_bus_model (
    input wire logic CLK, // system clock
    input wire logic XRDY_OE_N, // high while ready is released
    input wire logic PRESET_N, // slave reset, active low
    input wire logic [7:0] DATA_BUS_OUT, // jam data from the bridge
    input wire logic DATA_BUS_OE_N, // low while jam data drives the bus
    output logic [15:0] ADDR, // slave address bus
    output logic [7:0] DATA_BUS_IN, // resolved data bus level
    output debug_bridge_pkg::status_t STATUS // slave status lines
);
    logic rdy_reg = 1'b0;
    initial ADDR = 16'h1234;
    // the cpu only moves a whole machine cycle per release, never mid-cycle
    always @(posedge CLK) begin
        rdy_reg <= XRDY_OE_N;
        if (!PRESET_N) ADDR <= 16'h0000;
        else if (XRDY_OE_N && !rdy_reg) ADDR <= ADDR + 16'h0101;
    end
    assign DATA_BUS_IN = DATA_BUS_OE_N ? (ADDR[7:0] ^ ADDR[15:8]) : DATA_BUS_OUT;
    assign STATUS = debug_bridge_pkg::status_t'(ADDR[15:8] ^ 8'hC3);
endmodule // slave_bus_model

/* File: tb/testbench.sv */
`timescale 1ns/1ps

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic strobe_n = 1'b1;
    logic [1:0] sel = 2'h0;
    logic [7:0] out_data = 8'h00;
    logic [7:0] in_data, bus_out, bus_in, key_code;
    logic [15:0] addr;
    debug_bridge_pkg::status_t status;
    logic bus_oe_n, xrdy, xrdy_oe_n, inject_n, preset_n, fready_n, mw, mw_oe_n, dsbl_n, phantom_n, kready_n;
    int fail_count = 0;
    int checks = 0;
    int n;
    always #20 clk = ~clk;
    debug_bridge debug_bridge_inst (.CLK(clk), .RST(rst), .HOST_OUT_DATA(out_data), .HOST_OUT_STROBE_N(strobe_n),
        .SELECT_LOW(sel[0]), .SELECT_HIGH(sel[1]), .HOST_IN_DATA(in_data), .ADDR(addr), .DATA_BUS_IN(bus_in),
        .DATA_BUS_OUT(bus_out), .DATA_BUS_OE_N(bus_oe_n), .STATUS(status), .XRDY_OUT(xrdy), .XRDY_OE_N(xrdy_oe_n),
        .DATA_INJECT_N(inject_n), .PRESET_N(preset_n), .FRONT_READY_N(fready_n), .MWRITE_OUT(mw),
        .MWRITE_OE_N(mw_oe_n), .DO_DSBL_N(dsbl_n), .PHANTOM_N(phantom_n), .KEY_READY_N(kready_n), .KEY_CODE(key_code));
    slave_bus_model slave_bus_model_inst (.CLK(clk), .XRDY_OE_N(xrdy_oe_n), .PRESET_N(preset_n),
        .DATA_BUS_OUT(bus_out), .DATA_BUS_OE_N(bus_oe_n), .ADDR(addr), .DATA_BUS_IN(bus_in), .STATUS(status));
    // ----------------------------------------------------------------
    // master port access
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // selects first, then one strobe pulse; called at a falling edge
    task automatic put(input logic [1:0] s, input logic [7:0] d);
        sel = s;
        out_data = d;
        @(negedge clk) strobe_n = 1'b0;
        @(negedge clk) strobe_n = 1'b1;
        @(negedge clk);
    endtask
    function automatic logic [7:0] mux_exp(input logic [1:0] s);
        case (s)
            2'h0: return addr[15:8];
            2'h1: return addr[7:0];
            2'h2: return bus_in;
            default: return status;
        endcase
    endfunction
    task automatic report_and_stop();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(key_code, 8'h00);
        chk({kready_n, phantom_n, dsbl_n, fready_n, preset_n, inject_n, bus_oe_n, xrdy_oe_n}, 8'hFF);
        put(2'h0, 8'hA5);
        chk(key_code, 8'hA5);
        put(2'h1, 8'h3C);
        chk(key_code, 8'h3C);
        put(2'h3, 8'hC3);
        chk(bus_out, 8'hC3);
        chk(key_code, 8'h3C);
        for (int i = 2; i < 8; i++) begin
            put(2'h2, ~(8'h01 << i));
            chk({kready_n, phantom_n, dsbl_n, fready_n, preset_n, inject_n, 2'h3}, ~(8'h01 << i));
            chk({mw_oe_n, mw, bus_oe_n, xrdy_oe_n, xrdy, 3'h0}, {~(i == 4), 1'b0, ~(i == 2), 1'b1, 4'h0});
            if (i == 2) chk(bus_in, 8'hC3);
            for (int s = 0; s < 4; s++) begin
                sel = 2'(s);
                #1 chk(in_data, mux_exp(2'(s)));
            end
        end
        put(2'h2, 8'hFC);
        chk({7'h00, xrdy_oe_n}, 8'h00);
        n = 0;
        put(2'h2, 8'hFE);
        repeat (40) @(negedge clk) n += int'(xrdy_oe_n);
        chk(8'(n), 8'(debug_bridge_pkg::STEP_CYCLES));
        chk(addr[7:0], 8'h01);
        n = 0;
        put(2'h2, 8'hFE);
        repeat (20) @(negedge clk) n += int'(xrdy_oe_n);
        chk(8'(n), 8'h00);
        put(2'h2, 8'hFF);
        chk({7'h00, xrdy_oe_n}, 8'h01);
        report_and_stop();
    end
endmodule // testbench
